// File: src/ufc_device.sv
// Notes on behaviour
// - Enhanced enable gates INTERRUPT_ENABLE[7:4], FIFO_CONTROL[5:4], MODEM_CONTROL[7:5] bits
// - Low enhanced bits pick software flow mode
// - Special detect flags match with second pause
// - Auto RTS halts/resumes at flow thresholds
// - Auto CTS halts transmit while CTS high
// - Divisor is sixteen bits, high and low
// - Host loads divisor before enabling sleep
// - Flow threshold holds halt and resume nibbles
// - Flow threshold written only when access enabled
// - Host keeps halt above resume before enabling
// - Trigger register holds transmit and receive nibbles
// - Trigger register written only when access enabled
// - Zero trigger nibble falls back to FIFO control
// - Ready bits show transmit space per channel
// - Ready bits show receive level or timeout
// - Ready register read at seven when enabled
// - Host loads divisor through divisor bank
// - Host loads flow characters through enhanced bank
// - Enhanced control reachable only in enhanced bank
`timescale 1ns/1ps
`include "ufc_map.svh"
module ufc_device
    import ufc_pkg::*;
#(
    parameter int LEVEL_W = 7
) (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // Peripheral bus
    ufc_bus_if.dev                  bus,
    // Channel A FIFO state
    input  wire logic               rx_valid_i,
    input  wire logic [7:0]         rx_data_i,
    input  wire logic [LEVEL_W-1:0] rx_level_i,
    input  wire logic [LEVEL_W-1:0] tx_free_i,
    input  wire logic               rx_timeout_i,
    // Channel B ready state
    input  wire logic               b_tx_ready_i,
    input  wire logic               b_rx_ready_i,
    // Modem pins
    input  wire logic               cts_n_i,
    output logic                    rts_n_o,
    output logic                    tx_halt_o,
    // Configuration out
    output logic [15:0]             divisor_o,
    output logic [3:0]              swfc_mode_o,
    output logic [7:0]              int_enable_o,
    output logic [7:0]              fifo_ctrl_o,
    output logic [7:0]              modem_ctrl_o,
    output logic [LEVEL_W-1:0]      tx_trig_o,
    output logic [LEVEL_W-1:0]      rx_trig_o,
    output logic                    special_char_o
);
    if (LEVEL_W < 7) begin : g_level_chk
        $error("LEVEL_W must cover 64");
    end

    logic [7:0] lcr_ff, ier_ff, fcr_ff, mcr_ff, efr_ff, dll_ff, dlh_ff;
    logic [7:0] tcr_ff, tlr_ff, flow_resume_char1_ff, flow_resume_char2_ff, flow_pause_char1_ff, flow_pause_char2_ff;
    logic [7:0] rdata_ff, nxt_rdata;
    logic       spec_ff, rts_auto_n_ff, rts_n_ff, halt_ff;
    logic [LEVEL_W-1:0] tx_trig_ff, rx_trig_ff;

    // Bank and address decode
    wire        sel_a     = ~bus.cs_a_n;
    wire        sel_any   = ~bus.cs_a_n | ~bus.cs_b_n;
    wire        bank_enh  = lcr_ff == `UFC_LCR_ENH;
    wire        bank_div  = lcr_ff[`UFC_LCR_DLAB] & ~bank_enh;
    wire        bank_norm = ~lcr_ff[`UFC_LCR_DLAB];
    wire        efr_en    = efr_ff[`UFC_EFR_EN];
    wire        ext_en    = efr_en & mcr_ff[`UFC_MCR_TCR_EN];
    wire        frdy_en   = mcr_ff[`UFC_MCR_FRDY_EN] & ~mcr_ff[`UFC_MCR_LOOP];
    wire        wr_a      = bus.wr & sel_a;
    wire        wr_norm   = wr_a & bank_norm;
    wire        wr_ier    = wr_norm & bus.addr == `UFC_OFF_IER;
    wire        wr_fcr    = wr_norm & bus.addr == `UFC_OFF_FCR;
    wire        wr_lcr    = wr_a & bus.addr == `UFC_OFF_LCR;
    wire        wr_mcr    = wr_norm & bus.addr == `UFC_OFF_MCR;
    wire        wr_tcr    = wr_norm & ext_en & bus.addr == `UFC_OFF_TCR;
    wire        wr_tlr    = wr_norm & ext_en & bus.addr == `UFC_OFF_TLR;
    wire        wr_dll    = wr_a & bank_div & bus.addr == `UFC_OFF_DLL;
    wire        wr_dlh    = wr_a & bank_div & bus.addr == `UFC_OFF_DLH;
    wire        wr_efr    = wr_a & bank_enh & bus.addr == `UFC_OFF_EFR;
    wire        wr_flow_resume_char1   = wr_a & bank_enh & bus.addr == `UFC_OFF_FLOW_RESUME_CHAR1;
    wire        wr_flow_resume_char2   = wr_a & bank_enh & bus.addr == `UFC_OFF_FLOW_RESUME_CHAR2;
    wire        wr_flow_pause_char1  = wr_a & bank_enh & bus.addr == `UFC_OFF_FLOW_PAUSE_CHAR1;
    wire        wr_flow_pause_char2  = wr_a & bank_enh & bus.addr == `UFC_OFF_FLOW_PAUSE_CHAR2;
    wire        rd_iir    = bus.rd & sel_a & bank_norm & bus.addr == `UFC_OFF_FCR;

    // Write masks under enhanced enable
    wire [7:0]  ier_keep  = efr_en ? 8'h00 : `UFC_IER_GATED;
    wire [7:0]  fcr_keep  = efr_en ? 8'h00 : `UFC_FCR_GATED;
    wire [7:0]  mcr_keep  = efr_en ? 8'h00 : `UFC_MCR_GATED;
    wire [7:0]  nxt_ier   = (ier_ff & ier_keep) | (bus.wdata & ~ier_keep);
    wire [7:0]  nxt_fcr   = (fcr_ff & fcr_keep) | (bus.wdata & ~fcr_keep);
    wire [7:0]  nxt_mcr   = (mcr_ff & mcr_keep) | (bus.wdata & ~mcr_keep);

    // FIFO-control trigger table lookup
    function automatic logic [LEVEL_W-1:0] fcr_trig(input logic [1:0] s);
        logic [6:0] v;
        v = `UFC_FCR_TRIG0;
        unique case (s)
            2'b00: v = `UFC_FCR_TRIG0;
            2'b01: v = `UFC_FCR_TRIG1;
            2'b10: v = `UFC_FCR_TRIG2;
            2'b11: v = `UFC_FCR_TRIG3;
        endcase
        return LEVEL_W'(v);
    endfunction

    // Trigger selection, nibble times four
    wire [LEVEL_W-1:0] tlr_tx = LEVEL_W'({tlr_ff[3:0], 2'b00});
    wire [LEVEL_W-1:0] tlr_rx = LEVEL_W'({tlr_ff[7:4], 2'b00});
    wire [LEVEL_W-1:0] nxt_tx_trig = (tlr_ff[3:0] != 4'h0) ? tlr_tx
                                   : fcr_trig(fcr_ff[`UFC_FCR_TXSEL]);
    wire [LEVEL_W-1:0] nxt_rx_trig = (tlr_ff[7:4] != 4'h0) ? tlr_rx
                                   : fcr_trig(fcr_ff[`UFC_FCR_RXSEL]);

    // Flow thresholds in bytes
    wire [LEVEL_W-1:0] halt_lvl   = LEVEL_W'({tcr_ff[3:0], 2'b00});
    wire [LEVEL_W-1:0] resume_lvl = LEVEL_W'({tcr_ff[7:4], 2'b00});
    wire        arts       = efr_ff[`UFC_EFR_ARTS];
    wire        at_halt    = rx_level_i >= halt_lvl;
    wire        at_resume  = rx_level_i <= resume_lvl;
    wire        nxt_rts_auto_n = at_halt ? 1'b1 : (at_resume ? 1'b0 : rts_auto_n_ff);
    wire        nxt_rts_n  = arts ? nxt_rts_auto_n : ~mcr_ff[`UFC_MCR_RTS];
    wire        nxt_halt   = efr_ff[`UFC_EFR_ACTS] & cts_n_i;

    // Special character match
    wire        spec_hit   = rx_valid_i & efr_ff[`UFC_EFR_SPEC] & (rx_data_i == flow_pause_char2_ff);
    wire        nxt_spec   = spec_hit | (spec_ff & ~rd_iir);

    // Ready status word
    wire        a_tx_rdy   = tx_free_i >= tx_trig_ff;
    wire        a_rx_rdy   = (rx_level_i > rx_trig_ff) | rx_timeout_i;
    wire [7:0]  frdy       = {2'b00, b_rx_ready_i, a_rx_rdy, 2'b00, b_tx_ready_i, a_tx_rdy};
    wire [7:0]  interrupt_identification        = {{2{fcr_ff[`UFC_FCR_EN]}}, 1'b0, spec_ff, 3'b000, ~spec_ff};

    // Read mux
    always_comb begin
        nxt_rdata = 8'h00;
        if (bus.rd && sel_any && bank_norm && frdy_en && bus.addr == `UFC_OFF_FRDY) begin
            nxt_rdata = frdy;
        end else if (bus.rd && sel_a) begin
            unique case (bus.addr)
                `UFC_OFF_DLL:  nxt_rdata = bank_enh ? 8'h00 : (bank_div ? dll_ff : 8'h00);
                `UFC_OFF_IER:  nxt_rdata = bank_enh ? 8'h00 : (bank_div ? dlh_ff : ier_ff);
                `UFC_OFF_FCR:  nxt_rdata = bank_enh ? efr_ff : (bank_div ? 8'h00 : interrupt_identification);
                `UFC_OFF_LCR:  nxt_rdata = lcr_ff;
                `UFC_OFF_MCR:  nxt_rdata = bank_enh ? flow_resume_char1_ff : mcr_ff;
                `UFC_OFF_FLOW_RESUME_CHAR2: nxt_rdata = bank_enh ? flow_resume_char2_ff : 8'h00;
                `UFC_OFF_TCR:  nxt_rdata = bank_enh ? flow_pause_char1_ff : (ext_en ? tcr_ff : 8'h00);
                `UFC_OFF_TLR:  nxt_rdata = bank_enh ? flow_pause_char2_ff : (ext_en ? tlr_ff : 8'h00);
            endcase
        end
    end

    // Control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lcr_ff <= `UFC_RST_BYTE;
            ier_ff <= `UFC_RST_BYTE;
            fcr_ff <= `UFC_RST_BYTE;
            mcr_ff <= `UFC_RST_BYTE;
            efr_ff <= `UFC_RST_BYTE;
            tcr_ff <= `UFC_RST_BYTE;
            tlr_ff <= `UFC_RST_BYTE;
        end else begin
            if (wr_lcr) lcr_ff <= bus.wdata;
            if (wr_ier) ier_ff <= nxt_ier;
            if (wr_fcr) fcr_ff <= nxt_fcr;
            if (wr_mcr) mcr_ff <= nxt_mcr;
            if (wr_efr) efr_ff <= bus.wdata;
            if (wr_tcr) tcr_ff <= bus.wdata;
            if (wr_tlr) tlr_ff <= bus.wdata;
        end
    end

    // Divisor and flow characters
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dll_ff   <= `UFC_RST_DIVL;
            dlh_ff   <= `UFC_RST_BYTE;
            flow_resume_char1_ff  <= `UFC_RST_BYTE;
            flow_resume_char2_ff  <= `UFC_RST_BYTE;
            flow_pause_char1_ff <= `UFC_RST_BYTE;
            flow_pause_char2_ff <= `UFC_RST_BYTE;
        end else begin
            if (wr_dll) dll_ff <= bus.wdata;
            if (wr_dlh) dlh_ff <= bus.wdata;
            if (wr_flow_resume_char1) flow_resume_char1_ff <= bus.wdata;
            if (wr_flow_resume_char2) flow_resume_char2_ff <= bus.wdata;
            if (wr_flow_pause_char1) flow_pause_char1_ff <= bus.wdata;
            if (wr_flow_pause_char2) flow_pause_char2_ff <= bus.wdata;
        end
    end

    // Status and pin flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_ff      <= `UFC_RST_BYTE;
            spec_ff       <= 1'b0;
            rts_auto_n_ff <= 1'b0;
            rts_n_ff      <= 1'b1;
            halt_ff       <= 1'b0;
            tx_trig_ff    <= fcr_trig(2'b00);
            rx_trig_ff    <= fcr_trig(2'b00);
        end else begin
            rdata_ff      <= nxt_rdata;
            spec_ff       <= nxt_spec;
            rts_auto_n_ff <= nxt_rts_auto_n;
            rts_n_ff      <= nxt_rts_n;
            halt_ff       <= nxt_halt;
            tx_trig_ff    <= nxt_tx_trig;
            rx_trig_ff    <= nxt_rx_trig;
        end
    end

    assign bus.rdata      = rdata_ff;
    assign rts_n_o        = rts_n_ff;
    assign tx_halt_o      = halt_ff;
    assign divisor_o      = {dlh_ff, dll_ff};
    assign swfc_mode_o    = efr_ff[`UFC_EFR_SWFC];
    assign int_enable_o   = ier_ff;
    assign fifo_ctrl_o    = fcr_ff;
    assign modem_ctrl_o   = mcr_ff;
    assign tx_trig_o      = tx_trig_ff;
    assign rx_trig_o      = rx_trig_ff;
    assign special_char_o = spec_ff;
endmodule // ufc_device

// File: src/ufc_map.svh
`ifndef UFC_MAP_SVH
`define UFC_MAP_SVH
// Register offsets, normal bank
`define UFC_OFF_IER      3'h1
`define UFC_OFF_FCR      3'h2
`define UFC_OFF_LCR      3'h3
`define UFC_OFF_MCR      3'h4
`define UFC_OFF_TCR      3'h6
`define UFC_OFF_TLR      3'h7
`define UFC_OFF_FRDY     3'h7
// Divisor bank
`define UFC_OFF_DLL      3'h0
`define UFC_OFF_DLH      3'h1
// Enhanced bank
`define UFC_OFF_EFR      3'h2
`define UFC_OFF_FLOW_RESUME_CHAR1     3'h4
`define UFC_OFF_FLOW_RESUME_CHAR2     3'h5
`define UFC_OFF_FLOW_PAUSE_CHAR1    3'h6
`define UFC_OFF_FLOW_PAUSE_CHAR2    3'h7
// Bank select codes
`define UFC_LCR_ENH      8'hBF
`define UFC_LCR_DLAB     7
// Field positions
`define UFC_EFR_SWFC     3:0
`define UFC_EFR_EN       4
`define UFC_EFR_SPEC     5
`define UFC_EFR_ARTS     6
`define UFC_EFR_ACTS     7
`define UFC_IER_GATED    8'hF0
`define UFC_FCR_GATED    8'h30
`define UFC_MCR_GATED    8'hE0
`define UFC_MCR_RTS      1
`define UFC_MCR_FRDY_EN  2
`define UFC_MCR_LOOP     4
`define UFC_MCR_TCR_EN   6
`define UFC_FCR_EN       0
`define UFC_FCR_TXSEL    5:4
`define UFC_FCR_RXSEL    7:6
// FIFO-control trigger table
`define UFC_FCR_TRIG0    7'h08
`define UFC_FCR_TRIG1    7'h10
`define UFC_FCR_TRIG2    7'h20
`define UFC_FCR_TRIG3    7'h38
// Reset values
`define UFC_RST_BYTE     8'h00
`define UFC_RST_DIVL     8'h01
// Host side wishbone map
`define UFC_WB_CMD       2'h0
`define UFC_WB_STAT      2'h1
`define UFC_CMD_WR       16
`define UFC_CMD_RD       17
`define UFC_CMD_CS       18
`define UFC_CMD_ADR      10:8
`define UFC_CMD_DAT      7:0
`endif

// File: src/ufc_pkg.sv
package ufc_pkg;
    typedef enum logic [1:0] {
        UFC_H_IDLE = 2'b00,
        UFC_H_WR   = 2'b01,
        UFC_H_RD   = 2'b10,
        UFC_H_CAP  = 2'b11
    } ufc_host_state_type;
endpackage

// File: src/ufc_bus_if.sv
`timescale 1ns/1ps
interface ufc_bus_if;
    logic       cs_a_n;
    logic       cs_b_n;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    modport dev  (input cs_a_n, cs_b_n, addr, wdata, wr, rd, output rdata);
    modport host (output cs_a_n, cs_b_n, addr, wdata, wr, rd, input rdata);
endinterface

// File: src/ufc_host.sv
`timescale 1ns/1ps
`include "ufc_map.svh"
module ufc_host
    import ufc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Peripheral bus
    ufc_bus_if.host          bus
);
    ufc_host_state_type st_ff, nxt_st;
    logic [2:0]  addr_ff;
    logic [7:0]  wdata_ff, rd_ff;
    logic        csb_ff, ack_ff;
    logic [31:0] dat_ff;

    // Orders arrive as CMD writes; STAT reports busy and read byte
    wire        req      = wb_cyc_i & wb_stb_i & ~ack_ff;
    wire [1:0]  word     = wb_adr_i[3:2];
    wire        cmd_wr   = req & wb_we_i & word == `UFC_WB_CMD & (&wb_sel_i[2:0]);
    wire        busy     = st_ff != UFC_H_IDLE;
    wire        go       = cmd_wr & ~busy;
    wire [31:0] stat     = {16'h0000, rd_ff, 7'h00, busy};
    wire [31:0] nxt_dat  = (word == `UFC_WB_STAT) ? stat : 32'h0000_0000;

    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            UFC_H_IDLE: begin
                if (go && wb_dat_i[`UFC_CMD_WR]) nxt_st = UFC_H_WR;
                else if (go && wb_dat_i[`UFC_CMD_RD]) nxt_st = UFC_H_RD;
            end
            UFC_H_WR:  nxt_st = UFC_H_IDLE;
            UFC_H_RD:  nxt_st = UFC_H_CAP;
            UFC_H_CAP: nxt_st = UFC_H_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff    <= UFC_H_IDLE;
            addr_ff  <= 3'h0;
            wdata_ff <= 8'h00;
            csb_ff   <= 1'b0;
            rd_ff    <= 8'h00;
            ack_ff   <= 1'b0;
            dat_ff   <= 32'h0000_0000;
        end else begin
            st_ff  <= nxt_st;
            ack_ff <= req;
            dat_ff <= nxt_dat;
            if (go) begin
                addr_ff  <= wb_dat_i[`UFC_CMD_ADR];
                wdata_ff <= wb_dat_i[`UFC_CMD_DAT];
                csb_ff   <= wb_dat_i[`UFC_CMD_CS];
            end
            if (st_ff == UFC_H_CAP) rd_ff <= bus.rdata;
        end
    end

    assign wb_ack_o   = ack_ff;
    assign wb_dat_o   = dat_ff;
    assign bus.cs_a_n = ~(busy & ~csb_ff);
    assign bus.cs_b_n = ~(busy & csb_ff);
    assign bus.addr   = addr_ff;
    assign bus.wdata  = wdata_ff;
    assign bus.wr     = st_ff == UFC_H_WR;
    assign bus.rd     = st_ff == UFC_H_RD;
endmodule // ufc_host

// File: bench/ufc_bus_checker.sv
`timescale 1ns/1ps
module ufc_bus_checker (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Peripheral bus
    input  wire logic       cs_a_n,
    input  wire logic       cs_b_n,
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    input  wire logic [7:0] rdata
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] lcr_ff, efr_ff, mcr_ff, dll_ff, dlh_ff, tcr_ff;
    // Shadow of the bank and gate state
    wire        wa    = wr && !cs_a_n;
    wire        ra    = rd && !cs_a_n;
    wire        enh   = lcr_ff == 8'hBF;
    wire        dvb   = lcr_ff[7] && !enh;
    wire        nrm   = !lcr_ff[7];
    wire        tcr_e = nrm && addr == 3'h6 && efr_ff[4] && mcr_ff[6];
    wire [7:0]  mcr_m = efr_ff[4] ? 8'hFF : 8'h1F;
    wire        frdy  = rd && !(cs_a_n && cs_b_n) && nrm && addr == 3'h7 && mcr_ff[2] && !mcr_ff[4];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {lcr_ff, efr_ff, mcr_ff, dlh_ff, tcr_ff} <= 40'h0;
            dll_ff <= 8'h01;
        end else if (wa) begin
            if (addr == 3'h3) lcr_ff <= wdata;
            if (enh && addr == 3'h2) efr_ff <= wdata;
            if (nrm && addr == 3'h4) mcr_ff <= (mcr_ff & ~mcr_m) | (wdata & mcr_m);
            if (dvb && addr == 3'h0) dll_ff <= wdata;
            if (dvb && addr == 3'h1) dlh_ff <= wdata;
            if (tcr_e) tcr_ff <= wdata;
        end
    end
    property p_wr_pulse; wr |=> !wr; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe held");
    property p_rd_pulse; rd |=> !rd; endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe held");
    property p_excl; wr |-> !rd; endproperty
    a_excl: assert property (p_excl) else $error("read with write");
    property p_idle; !rd |=> rdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data without read");
    property p_efr; ra && enh && addr == 3'h2 |=> rdata == efr_ff; endproperty
    a_efr: assert property (p_efr) else $error("feature control readback");
    property p_div; ra && dvb && addr[2:1] == 2'h0 |=> rdata == ($past(addr[0]) ? dlh_ff : dll_ff);
    endproperty
    a_div: assert property (p_div) else $error("divisor readback");
    property p_tcr; ra && tcr_e |=> rdata == tcr_ff; endproperty
    a_tcr: assert property (p_tcr) else $error("threshold readback");
    property p_frdy; frdy |=> (rdata & 8'hCC) == 8'h00; endproperty
    a_frdy: assert property (p_frdy) else $error("ready unused bits set");
    c_frdy: cover property (frdy);
    c_tcr: cover property (ra && tcr_e);
    c_efr: cover property (ra && enh && addr == 3'h2);
endmodule // ufc_bus_checker

// File: bench/uart_flow_ctrl_config_tb_top.sv
`timescale 1ns/1ps
module uart_flow_ctrl_config_tb_top;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, wb_ack_o;
    logic [3:0]  adr = 4'h0, swfc_mode_o;
    logic [31:0] dat = 32'h0, q, wb_dat_o;
    logic        rx_valid = 1'b0, rx_to = 1'b0, btx = 1'b0, brx = 1'b0, cts_n = 1'b0;
    logic        rts_n_o, tx_halt_o, special_char_o;
    logic [7:0]  rx_data = 8'h00, v, int_enable_o, fifo_ctrl_o, modem_ctrl_o;
    logic [6:0]  rx_level = 7'h00, tx_free = 7'h00, tx_trig_o, rx_trig_o;
    logic [15:0] divisor_o;
    logic [6:0]  lv [5] = '{7'h00, 7'h0F, 7'h10, 7'h09, 7'h08};
    logic [16:0] fr [3] = '{{7'h38, 7'h0C, 3'h0}, {7'h37, 7'h0D, 3'h2}, {7'h00, 7'h00, 3'h5}};
    int          num_errors = 0, tests_run = 0, cyc_cnt = 0;
    ufc_bus_if ufc_bus_if_i ();
    ufc_host ufc_host_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .bus(ufc_bus_if_i));
    ufc_device ufc_device_i (.clk_i(clk_i), .rst_i(rst_i), .bus(ufc_bus_if_i),
        .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_level_i(rx_level), .tx_free_i(tx_free),
        .rx_timeout_i(rx_to), .b_tx_ready_i(btx), .b_rx_ready_i(brx), .cts_n_i(cts_n),
        .rts_n_o(rts_n_o), .tx_halt_o(tx_halt_o), .divisor_o(divisor_o),
        .swfc_mode_o(swfc_mode_o), .int_enable_o(int_enable_o), .fifo_ctrl_o(fifo_ctrl_o),
        .modem_ctrl_o(modem_ctrl_o), .tx_trig_o(tx_trig_o), .rx_trig_o(rx_trig_o),
        .special_char_o(special_char_o));
    ufc_bus_checker ufc_bus_checker_i (.clk_i(clk_i), .rst_i(rst_i),
        .cs_a_n(ufc_bus_if_i.cs_a_n), .cs_b_n(ufc_bus_if_i.cs_b_n), .addr(ufc_bus_if_i.addr),
        .wdata(ufc_bus_if_i.wdata), .wr(ufc_bus_if_i.wr), .rd(ufc_bus_if_i.rd),
        .rdata(ufc_bus_if_i.rdata));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic wrap_up;
        $display("errors=%0d checks=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            num_errors++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One classic cycle; waits for ack, the cycle ceiling ends a hang
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {cyc, stb} <= 2'h0;
    endtask
    // Device access through the command register, then poll until idle
    task automatic acc(input logic r, input logic b, input logic [2:0] a, input logic [7:0] d);
        wb(1'b1, 4'h0, {13'h0, b, r, !r, 5'h0, a, d});
        do begin
            wb(1'b0, 4'h4, 32'h0);
        end while (q[0] !== 1'b0);
        v = q[15:8];
    endtask
    task automatic rxc(input logic [7:0] d, input logic [31:0] e);
        @(posedge clk_i);
        {rx_valid, rx_data} <= {1'b1, d};
        @(posedge clk_i);
        rx_valid <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(special_char_o, e);
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({divisor_o, rts_n_o, tx_trig_o, rx_trig_o}, 31'h0000C408);
        acc(0, 0, 3'h3, 8'h80);
        acc(0, 0, 3'h0, 8'h34);
        acc(0, 0, 3'h1, 8'h12);
        chk(divisor_o, 16'h1234);
        acc(1, 0, 3'h0, 8'h00);
        chk(v, 8'h34);
        acc(0, 0, 3'h3, 8'h00);
        acc(0, 0, 3'h1, 8'hFF);
        acc(0, 0, 3'h2, 8'hF1);
        acc(0, 0, 3'h4, 8'hE0);
        chk({int_enable_o, fifo_ctrl_o, modem_ctrl_o}, 24'h0FC100);
        acc(0, 0, 3'h3, 8'hBF);
        acc(0, 0, 3'h2, 8'h1A);
        acc(0, 0, 3'h3, 8'h00);
        chk(swfc_mode_o, 4'hA);
        acc(0, 0, 3'h1, 8'hFF);
        acc(0, 0, 3'h2, 8'hF1);
        acc(0, 0, 3'h4, 8'hA0);
        acc(0, 0, 3'h7, 8'h35);
        acc(0, 0, 3'h6, 8'h21);
        chk({int_enable_o, fifo_ctrl_o, modem_ctrl_o}, 24'hFFF1A0);
        chk({tx_trig_o, rx_trig_o}, 14'h1C38);
        acc(0, 0, 3'h4, 8'h40);
        acc(1, 0, 3'h6, 8'h00);
        chk(v, 8'h00);
        acc(0, 0, 3'h6, 8'h24);
        acc(1, 0, 3'h6, 8'h00);
        chk(v, 8'h24);
        acc(0, 0, 3'h7, 8'h05);
        chk({tx_trig_o, rx_trig_o}, 14'h0A38);
        acc(0, 0, 3'h7, 8'h30);
        chk({tx_trig_o, rx_trig_o}, 14'h1C0C);
        cts_n <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk({rts_n_o, tx_halt_o}, 2'h2);
        acc(0, 0, 3'h3, 8'hBF);
        acc(0, 0, 3'h7, 8'h13);
        acc(0, 0, 3'h2, 8'hFA);
        acc(1, 0, 3'h2, 8'h00);
        chk(v, 8'hFA);
        acc(0, 0, 3'h3, 8'h00);
        chk(tx_halt_o, 1'b1);
        cts_n <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            rx_level <= lv[i];
            repeat (3) @(posedge clk_i);
            chk({tx_halt_o, rts_n_o}, {1'b0, i == 2 || i == 3});
        end
        rxc(8'h11, 0);
        rxc(8'h13, 1);
        acc(1, 0, 3'h2, 8'h00);
        chk({v, special_char_o}, 9'h1A0);
        acc(1, 0, 3'h2, 8'h00);
        chk(v, 8'hC1);
        acc(0, 0, 3'h4, 8'h44);
        for (int i = 0; i < 3; i++) begin
            {tx_free, rx_level, rx_to, btx, brx} <= fr[i];
            repeat (2) @(posedge clk_i);
            acc(1, i[0], 3'h7, 8'h00);
            chk(v, 24'h301201 >> (i * 8) & 8'hFF);
        end
        {rx_to, brx} <= 2'h0;
        acc(0, 0, 3'h4, 8'h54);
        acc(1, 0, 3'h7, 8'h00);
        chk(v, 8'h30);
        acc(0, 0, 3'h2, 8'h01);
        chk(swfc_mode_o, 4'hA);
        wrap_up();
    end
endmodule // uart_flow_ctrl_config_tb_top
